// ===== bench/scce_engine_model.sv
// Behavioural protocol engine that answers the command interpreter
`timescale 1ns/1ns
module scce_engine_model
  import scce_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire scce_req_s  req_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [7:0] dly_i,
  input  wire logic [7:0] code_i,
  output logic            done_o,
  output scce_rsp_s       rsp_o
);
  logic       busy;
  logic       abt;
  logic [7:0] cnt;

  // Busy countdown; the answer bus toggles outside done so stale values never match
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy   <= 1'b0;
      abt    <= 1'b0;
      cnt    <= 8'h00;
      done_o <= 1'b0;
      rsp_o  <= '0;
    end else begin
      done_o <= 1'b0;
      rsp_o  <= ~rsp_o;
      if (start_i) begin
        busy <= 1'b1;
        abt  <= 1'b0;
        cnt  <= dly_i;
      end else if (busy) begin
        if (abort_i) abt <= 1'b1;
        if (cnt == 8'h00) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
          // Whole length counts as moved; channel query hands back a parameter
          rsp_o  <= '{code: (abort_i || abt) ? 8'h01 : code_i, count: req_i.len,
                      param_vld: (req_i.func == 7'h01), param1: req_i.param2 + 32'h1};
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule // scce_engine_model

// ===== bench/tb_sync_comm_command_element.sv
// Self-checking bench for the command element interpreter
`timescale 1ns/1ns
`include "scce_regs.svh"
module tb_sync_comm_command_element
  import scce_pkg::*;
;
  logic        CLK_I = 1'b0;
  logic        ARST_N_I = 1'b0;
  logic [2:0]  AVS_ADDRESS_I = 3'h0;
  logic        AVS_READ_I = 1'b0;
  logic        AVS_WRITE_I = 1'b0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0;
  logic [3:0]  AVS_BYTEENABLE_I = 4'h0;
  logic [31:0] AVS_READDATA_O;
  logic        AVS_WAITREQUEST_O;
  scce_req_s   ENG_REQ_O;
  logic        ENG_START_O;
  logic        ENG_ABORT_O;
  logic        ENG_DONE_I;
  scce_rsp_s   ENG_RSP_I;
  logic        RESPONSE_AVAILABLE_FLAG_O;
  logic [7:0]  eng_dly = 8'h00;
  logic [7:0]  eng_code = 8'h00;
  int          error_cnt = 0;
  int          n_tests = 0;
  bit          rdy [2];
  bit          went;
  logic [31:0] q;
  logic [6:0]  unk [4] = '{7'h12, 7'h21, 7'h31, 7'h7E};
  logic [7:0]  ecd [11] = '{8'h00, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11,
                            8'h02, 8'h7F};
  logic [6:0]  oth [6] = '{7'h01, 7'h11, 7'h40, 7'h50, 7'h7F, 7'h13};

  scce_top uut (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .ENG_REQ_O(ENG_REQ_O), .ENG_START_O(ENG_START_O),
    .ENG_ABORT_O(ENG_ABORT_O), .ENG_DONE_I(ENG_DONE_I), .ENG_RSP_I(ENG_RSP_I),
    .RESPONSE_AVAILABLE_FLAG_O(RESPONSE_AVAILABLE_FLAG_O));

  scce_engine_model u_eng (.clk_i(CLK_I), .arst_n_i(ARST_N_I), .req_i(ENG_REQ_O),
    .start_i(ENG_START_O), .abort_i(ENG_ABORT_O), .dly_i(eng_dly), .code_i(eng_code),
    .done_o(ENG_DONE_I), .rsp_o(ENG_RSP_I));

  // Free-running 100 MHz clock
  initial begin
    forever #5 CLK_I = ~CLK_I;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                     output logic [31:0] rq);
    int n;
    n = 0;
    AVS_ADDRESS_I    <= a;
    AVS_WRITEDATA_I  <= d;
    AVS_BYTEENABLE_I <= 4'hF;
    AVS_WRITE_I      <= wr;
    AVS_READ_I       <= !wr;
    do begin
      @(posedge CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 100);
    rq = AVS_READDATA_O;
    if (n >= 100) chk(32'h1, 32'h0, "bus stuck");
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I  <= 1'b0;
    @(posedge CLK_I);
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [2:0] a, output logic [31:0] rq);
    bus(1'b0, a, 32'h0, rq);
  endtask

  // Reference outcome of one block; also notes whether the engine should run
  function automatic logic [7:0] expc(input logic [6:0] fn, input logic [7:0] ch,
      input logic [31:0] len, input logic [31:0] addr, input logic [7:0] ec, input logic abt);
    logic bf;
    went = 1'b0;
    bf = fn inside {7'h10, 7'h11, 7'h20, 7'h30};
    if (!(fn inside {7'h00, 7'h01, 7'h10, 7'h11, 7'h13, 7'h20, 7'h30, 7'h40, 7'h50, 7'h7F}))
      return 8'h03;
    if (fn == 7'h00) return 8'h00;
    if (ch > 8'h01) return 8'h04;
    if (bf && addr[31:22] != 10'h0) return 8'h05;
    if (bf && len[31:16] == 16'h0) return 8'h06;
    if (fn inside {7'h20, 7'h30} && !rdy[ch[0]]) return 8'h09;
    went = 1'b1;
    if (abt) return 8'h01;
    if (ec == 8'h02 || ec > 8'h11) return 8'h11;
    return ec;
  endfunction

  // Submit one block, wait for its response, check it and acknowledge it
  task automatic run(input logic [6:0] fn, input logic [7:0] ch, input logic [31:0] len,
      input logic [31:0] addr, input logic [7:0] ec, input logic last, input logic abt);
    logic [31:0] first_parameter_word;
    logic [31:0] second_parameter_word;
    logic [31:0] r;
    logic [7:0]  c;
    int          n;
    first_parameter_word = $urandom;
    second_parameter_word = $urandom;
    c = expc(fn, ch, len, addr, ec, abt);
    eng_code <= ec;
    eng_dly  <= abt ? 8'h28 : 8'($urandom_range(0, 6));
    wr(3'h0, {16'h0, ch, 1'b0, fn});
    wr(3'h1, len);
    wr(3'h2, addr);
    wr(3'h3, first_parameter_word);
    wr(3'h4, second_parameter_word);
    wr(3'h5, {29'h0, last, 2'b01});
    if (abt) begin
      wr(3'h0, 32'hFFFFFFFF);
      wr(3'h5, 32'h2);
    end
    n = 0;
    while (RESPONSE_AVAILABLE_FLAG_O !== 1'b1 && n < 200) begin
      @(posedge CLK_I);
      n++;
    end
    if (n >= 200) chk(32'h1, 32'h0, "no response posted");
    rd(3'h0, r);
    chk(r, {c, 2'b00, last, 1'b1, 4'h0, ch, 1'b0, fn}, "function word");
    rd(3'h3, r);
    chk(r, (fn == 7'h00) ? {8'h00, 8'h02, `SCCE_FW_VERSION, `SCCE_DEV_CODE} :
           (fn == 7'h01 && went) ? second_parameter_word + 32'h1 : first_parameter_word,
        "first parameter");
    if (went) begin
      rd(3'h1, r);
      chk(r, {len[31:16], len[31:16]}, "length word");
      chk({10'h0, ENG_REQ_O.addr}, {10'h0, addr[21:0]}, "engine address");
      chk(ENG_REQ_O.param2, second_parameter_word, "second parameter");
    end
    if (c == 8'h00 && fn == 7'h10) rdy[ch[0]] = 1'b1;
    if (c == 8'h00 && fn == 7'h13) rdy[ch[0]] = 1'b0;
    wr(3'h6, 32'h1);
    rd(3'h6, r);
    chk({30'h0, r[1:0]}, 32'h0, "status after acknowledge");
  endtask

  // Watchdog sized well beyond the expected run length
  initial begin
    repeat (40000) @(posedge CLK_I);
    error_cnt++;
    $display("ERROR %0t run did not finish", $time);
    conclude();
  end

  // Main sequence
  initial begin
    void'($urandom(90677));
    repeat (16) @(posedge CLK_I);
    ARST_N_I <= 1'b1;
    @(posedge CLK_I);
    rd(3'h6, q);
    chk(q, 32'h0, "status at reset");
    wr(3'h7, 32'hA5A5A5A5);
    rd(3'h7, q);
    chk(q, 32'h0, "unmapped word");
    run(7'h00, 8'($urandom), $urandom, $urandom, 8'h00, 1'b1, 1'b0);
    foreach (unk[i]) run(unk[i], 8'h00, 32'h00100000, 32'h0, 8'h00, 1'b0, 1'b0);
    run(7'h01, 8'($urandom_range(2, 255)), 32'h0, 32'h0, 8'h00, 1'b0, 1'b0);
    run(7'h20, 8'h00, 32'h00100000, 32'h1000, 8'h00, 1'b0, 1'b0);
    run(7'h10, 8'h00, 32'h00100000, 32'h003FFFF0, 8'h00, 1'b0, 1'b0);
    run(7'h10, 8'h01, 32'h00100000, 32'h00000010, 8'h00, 1'b0, 1'b0);
    run(7'h20, 8'h01, 32'h00100000, 32'h00400000, 8'h00, 1'b0, 1'b0);
    run(7'h30, 8'h00, 32'h0000FFFF, 32'h100, 8'h00, 1'b0, 1'b0);
    foreach (ecd[i]) run(i[0] ? 7'h30 : 7'h20, 8'(i % 2), {16'($urandom_range(1, 65535)), 16'h0},
        {10'h0, 22'($urandom)}, ecd[i], i == 4, 1'b0);
    run(7'h30, 8'h01, 32'h00400000, 32'h2000, 8'h00, 1'b0, 1'b1);
    foreach (oth[i]) run(oth[i], 8'h00, 32'h00100000, 32'h0, 8'h00, 1'b0, 1'b0);
    run(7'h20, 8'h00, 32'h00100000, 32'h3000, 8'h00, 1'b1, 1'b0);
    conclude();
  end
endmodule // tb_sync_comm_command_element

// ===== hdl/scce_decode.sv
// Validation of a submitted command block
`timescale 1ns/1ns
`include "scce_regs.svh"
module scce_decode
  import scce_pkg::*;
(
  input  wire logic [31:0] func_i,
  input  wire logic [31:0] len_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  chan_ready_i,
  output logic [7:0]       code_o,
  output logic             engine_o
);
  scce_func_s fw;
  logic       known;
  logic       bufcmd;

  // Classify the function code
  always_comb begin
    fw     = scce_func_s'(func_i);
    known  = fw.code inside {`SCCE_FN_DEVPAR, `SCCE_FN_CHPAR, `SCCE_FN_INIT,
                             `SCCE_FN_UPDATE, `SCCE_FN_RESET, `SCCE_FN_XMIT,
                             `SCCE_FN_RECV, `SCCE_FN_MODEM, `SCCE_FN_STCHG,
                             `SCCE_FN_MAINT};
    bufcmd = fw.code inside {`SCCE_FN_INIT, `SCCE_FN_UPDATE, `SCCE_FN_XMIT,
                             `SCCE_FN_RECV};
  end

  // First failing check decides the code
  always_comb begin
    code_o   = `SCCE_CC_OK;
    engine_o = 1'b0;
    if (!known) begin
      code_o = `SCCE_CC_UNKNOWN;
    end else if (fw.code == `SCCE_FN_DEVPAR) begin
      code_o = `SCCE_CC_OK;
    end else if (fw.chan > `SCCE_CHAN_MAX) begin
      code_o = `SCCE_CC_CHAN;
    end else if (bufcmd && addr_i[`SCCE_ADDR_HI] != 10'h000) begin
      code_o = `SCCE_CC_LW1;
    end else if (bufcmd && len_i[31:16] == 16'h0000) begin
      code_o = `SCCE_CC_LW2;
    end else if ((fw.code == `SCCE_FN_XMIT || fw.code == `SCCE_FN_RECV)
                 && !chan_ready_i[fw.chan[0]]) begin
      code_o = `SCCE_CC_SEQ;
    end else begin
      engine_o = 1'b1;
    end
  end
endmodule // scce_decode

// ===== hdl/scce_pkg.sv
// Types shared by the command element block
package scce_pkg;
  // Function longword layout
  typedef struct packed {
    logic [7:0] status;
    logic [1:0] flag_hi;
    logic       eol;
    logic       inprog;
    logic [3:0] flag_lo;
    logic [7:0] chan;
    logic       spare;
    logic [6:0] code;
  } scce_func_s;
  // Work handed to the protocol engine
  typedef struct packed {
    logic [6:0]  func;
    logic        chan;
    logic [21:0] addr;
    logic [15:0] len;
    logic [31:0] param2;
  } scce_req_s;
  // Result returned by the protocol engine
  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] count;
    logic        param_vld;
    logic [31:0] param1;
  } scce_rsp_s;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_ENGINE = 3'b010,
    ST_WBACK  = 3'b011,
    ST_POST   = 3'b100
  } scce_state_e;
endpackage

// ===== hdl/scce_regs.svh
// Register map, field positions and codes of the command element block
`ifndef SCCE_REGS_SVH
`define SCCE_REGS_SVH
`define SCCE_IDX_FUNC    3'h0
`define SCCE_IDX_LEN     3'h1
`define SCCE_IDX_ADDR    3'h2
`define SCCE_IDX_PARAM1  3'h3
`define SCCE_IDX_PARAM2  3'h4
`define SCCE_IDX_CTRL    3'h5
`define SCCE_IDX_STAT    3'h6
`define SCCE_CTRL_SUBMIT 0
`define SCCE_CTRL_ABORT  1
`define SCCE_CTRL_LAST   2
`define SCCE_STAT_AVAIL  0
`define SCCE_STAT_BUSY   1
`define SCCE_STAT_CHRDY  2
`define SCCE_BIT_INPROG  20
`define SCCE_BIT_EOL     21
`define SCCE_FN_DEVPAR   7'h00
`define SCCE_FN_CHPAR    7'h01
`define SCCE_FN_INIT     7'h10
`define SCCE_FN_UPDATE   7'h11
`define SCCE_FN_RESET    7'h13
`define SCCE_FN_XMIT     7'h20
`define SCCE_FN_RECV     7'h30
`define SCCE_FN_MODEM    7'h40
`define SCCE_FN_STCHG    7'h50
`define SCCE_FN_MAINT    7'h7F
`define SCCE_CC_OK       8'h00
`define SCCE_CC_ABORT    8'h01
`define SCCE_CC_RSVD     8'h02
`define SCCE_CC_UNKNOWN  8'h03
`define SCCE_CC_CHAN     8'h04
`define SCCE_CC_LW1      8'h05
`define SCCE_CC_LW2      8'h06
`define SCCE_CC_SEQ      8'h09
`define SCCE_CC_MSG      8'h11
`define SCCE_CHAN_MAX    8'h01
`define SCCE_LINE_COUNT  8'h02
`define SCCE_FW_VERSION  8'h03
`define SCCE_DEV_CODE    8'h5A // Arbitrary value, names no real part
`define SCCE_ADDR_HI     31:22
`define SCCE_ADDR_LO     21:0
`endif

// ===== hdl/scce_store.sv
// Command block storage shared by host writes and device write-back
`timescale 1ns/1ns
`include "scce_regs.svh"
module scce_store
  import scce_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        host_we_i,
  input  wire logic [2:0]  host_idx_i,
  input  wire logic [31:0] host_data_i,
  input  wire logic [3:0]  host_be_i,
  input  wire logic        dev_func_we_i,
  input  wire logic [31:0] dev_func_i,
  input  wire logic        dev_len_we_i,
  input  wire logic [15:0] dev_len_i,
  input  wire logic        dev_prm_we_i,
  input  wire logic [31:0] dev_prm_i,
  output logic [31:0]      word_o [5]
);
  logic [31:0] mem      [5];
  logic [31:0] next_mem [5];

  // Merge byte lanes of a host write
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Device write-back wins; top only lets host write while idle
  always_comb begin
    next_mem = mem;
    if (host_we_i && host_idx_i <= `SCCE_IDX_PARAM2) begin
      next_mem[host_idx_i] = lanes(mem[host_idx_i], host_data_i, host_be_i);
    end
    if (dev_func_we_i) begin
      next_mem[`SCCE_IDX_FUNC] = dev_func_i;
    end
    if (dev_len_we_i) begin
      next_mem[`SCCE_IDX_LEN][15:0] = dev_len_i;
    end
    if (dev_prm_we_i) begin
      next_mem[`SCCE_IDX_PARAM1] = dev_prm_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 5; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else begin
      mem <= next_mem;
    end
  end

  assign word_o = mem;
endmodule // scce_store

// ===== hdl/scce_top.sv
// Command element interpreter with Avalon-MM register slave
`timescale 1ns/1ns
`include "scce_regs.svh"
module scce_top
  import scce_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic [2:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output scce_req_s        ENG_REQ_O,
  output logic             ENG_START_O,
  output logic             ENG_ABORT_O,
  input  wire logic        ENG_DONE_I,
  input  wire scce_rsp_s   ENG_RSP_I,
  output logic             RESPONSE_AVAILABLE_FLAG_O
);
  logic [31:0] word [5];
  logic [7:0]  val_code;
  logic        val_engine;
  scce_func_s  fw;

  scce_state_e state, next_state;
  logic        response_available_flag, next_response_available_flag;
  logic        eol_req, next_eol_req;
  logic [1:0]  chan_ready, next_chan_ready;
  logic [7:0]  code, next_code;
  logic [15:0] count, next_count;
  logic [31:0] first_parameter_word, next_first_parameter_word;
  logic        first_parameter_vld, next_first_parameter_vld;
  scce_req_s   req, next_req;
  logic        start, next_start;
  logic        abort, next_abort;
  logic        waitreq, next_waitreq;
  logic [31:0] rdata, next_rdata;

  logic        host_we;
  logic        bus_wr;
  logic        submit;
  logic        dev_func_we;
  logic [31:0] dev_func;
  logic        dev_len_we;
  logic        dev_prm_we;

  scce_store u_store (
    .clk_i         (CLK_I),
    .arst_n_i      (ARST_N_I),
    .host_we_i     (host_we),
    .host_idx_i    (AVS_ADDRESS_I),
    .host_data_i   (AVS_WRITEDATA_I),
    .host_be_i     (AVS_BYTEENABLE_I),
    .dev_func_we_i (dev_func_we),
    .dev_func_i    (dev_func),
    .dev_len_we_i  (dev_len_we),
    .dev_len_i     (count),
    .dev_prm_we_i  (dev_prm_we),
    .dev_prm_i     (first_parameter_word),
    .word_o        (word)
  );

  scce_decode u_decode (
    .func_i       (word[`SCCE_IDX_FUNC]),
    .len_i        (word[`SCCE_IDX_LEN]),
    .addr_i       (word[`SCCE_IDX_ADDR]),
    .chan_ready_i (chan_ready),
    .code_o       (val_code),
    .engine_o     (val_engine)
  );

  // Write lands at the edge where the master sees waitrequest low
  assign bus_wr  = AVS_WRITE_I && !waitreq;
  assign host_we = bus_wr && state == ST_IDLE && AVS_ADDRESS_I <= `SCCE_IDX_PARAM2;
  assign submit  = bus_wr && AVS_ADDRESS_I == `SCCE_IDX_CTRL
                   && AVS_WRITEDATA_I[`SCCE_CTRL_SUBMIT] && AVS_BYTEENABLE_I[0];
  assign fw      = scce_func_s'(word[`SCCE_IDX_FUNC]);

  // Legal completion codes only; reserved 02 and values above 11 collapse to 11
  function automatic logic [7:0] legal_code(input logic [7:0] c);
    if (c == `SCCE_CC_RSVD || c > `SCCE_CC_MSG) begin
      return `SCCE_CC_MSG;
    end
    return c;
  endfunction

  // Device writes into the block: in-progress mark, then the response
  always_comb begin
    dev_func    = word[`SCCE_IDX_FUNC];
    dev_func_we = 1'b0;
    dev_len_we  = 1'b0;
    dev_prm_we  = 1'b0;
    if (state == ST_CHECK) begin
      dev_func_we                 = 1'b1;
      dev_func[`SCCE_BIT_INPROG]  = 1'b1;
    end
    if (state == ST_WBACK) begin
      dev_func_we                = 1'b1;
      dev_func[31:24]            = code;
      dev_func[`SCCE_BIT_INPROG] = 1'b1;
      dev_func[`SCCE_BIT_EOL]    = eol_req;
      dev_len_we                 = fw.code != `SCCE_FN_DEVPAR;
      dev_prm_we                 = first_parameter_vld;
    end
  end

  // Command sequencing
  always_comb begin
    next_state      = state;
    next_eol_req    = eol_req;
    next_chan_ready = chan_ready;
    next_code       = code;
    next_count      = count;
    next_first_parameter_word = first_parameter_word;
    next_first_parameter_vld  = first_parameter_vld;
    next_req        = req;
    next_start      = 1'b0;
    next_abort      = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (submit) begin
          next_state   = ST_CHECK;
          next_eol_req = AVS_WRITEDATA_I[`SCCE_CTRL_LAST];
        end
      end
      ST_CHECK: begin
        next_code   = val_code;
        next_count  = 16'h0000;
        next_first_parameter_vld = 1'b0;
        if (fw.code == `SCCE_FN_DEVPAR && val_code == `SCCE_CC_OK) begin
          next_first_parameter_word = {8'h00, `SCCE_LINE_COUNT,
                                       `SCCE_FW_VERSION, `SCCE_DEV_CODE};
          next_first_parameter_vld  = 1'b1;
          next_state  = ST_WBACK;
        end else if (val_engine) begin
          next_req.func   = fw.code;
          next_req.chan   = fw.chan[0];
          next_req.addr   = word[`SCCE_IDX_ADDR][`SCCE_ADDR_LO];
          next_req.len    = word[`SCCE_IDX_LEN][31:16];
          next_req.param2 = word[`SCCE_IDX_PARAM2];
          next_start      = 1'b1;
          next_state      = ST_ENGINE;
        end else begin
          next_state = ST_WBACK;
        end
      end
      ST_ENGINE: begin
        // Abort only asks; the engine still answers, normally with 01
        next_abort = bus_wr && AVS_ADDRESS_I == `SCCE_IDX_CTRL
                     && AVS_WRITEDATA_I[`SCCE_CTRL_ABORT];
        if (ENG_DONE_I) begin
          next_code   = legal_code(ENG_RSP_I.code);
          next_count  = ENG_RSP_I.count;
          next_first_parameter_word = ENG_RSP_I.param1;
          next_first_parameter_vld  = ENG_RSP_I.param_vld;
          next_state  = ST_WBACK;
          if (req.func == `SCCE_FN_INIT && ENG_RSP_I.code == `SCCE_CC_OK) begin
            next_chan_ready[req.chan] = 1'b1;
          end
          if (req.func == `SCCE_FN_RESET) begin
            next_chan_ready[req.chan] = 1'b0;
          end
        end
      end
      ST_WBACK: begin
        next_state = ST_POST;
      end
      ST_POST: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Response flag: posting sets it, software clears by writing one; set wins
  always_comb begin
    next_response_available_flag = response_available_flag;
    if (bus_wr && AVS_ADDRESS_I == `SCCE_IDX_STAT && AVS_WRITEDATA_I[`SCCE_STAT_AVAIL]) begin
      next_response_available_flag = 1'b0;
    end
    if (state == ST_POST) begin
      next_response_available_flag = 1'b1;
    end
  end

  // Bus slave: one wait cycle per access, unmapped reads return zero
  always_comb begin
    next_waitreq = !((AVS_READ_I || AVS_WRITE_I) && waitreq);
    next_rdata   = rdata;
    if (AVS_READ_I && waitreq) begin
      next_rdata = 32'h0000_0000;
      if (AVS_ADDRESS_I <= `SCCE_IDX_PARAM2) begin
        next_rdata = word[AVS_ADDRESS_I];
      end else if (AVS_ADDRESS_I == `SCCE_IDX_CTRL) begin
        next_rdata[`SCCE_CTRL_LAST] = eol_req;
      end else if (AVS_ADDRESS_I == `SCCE_IDX_STAT) begin
        next_rdata[`SCCE_STAT_AVAIL]          = response_available_flag;
        next_rdata[`SCCE_STAT_BUSY]           = state != ST_IDLE;
        next_rdata[`SCCE_STAT_CHRDY +: 2]     = chan_ready;
      end
    end
  end

  // All state registers
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state      <= ST_IDLE;
      response_available_flag <= 1'b0;
      eol_req    <= 1'b0;
      chan_ready <= 2'h0;
      code       <= 8'h00;
      count      <= 16'h0000;
      first_parameter_word <= 32'h0000_0000;
      first_parameter_vld  <= 1'b0;
      req        <= '0;
      start      <= 1'b0;
      abort      <= 1'b0;
      waitreq    <= 1'b1;
      rdata      <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      response_available_flag <= next_response_available_flag;
      eol_req    <= next_eol_req;
      chan_ready <= next_chan_ready;
      code       <= next_code;
      count      <= next_count;
      first_parameter_word <= next_first_parameter_word;
      first_parameter_vld  <= next_first_parameter_vld;
      req        <= next_req;
      start      <= next_start;
      abort      <= next_abort;
      waitreq    <= next_waitreq;
      rdata      <= next_rdata;
    end
  end

  assign AVS_READDATA_O    = rdata;
  assign AVS_WAITREQUEST_O = waitreq;
  assign ENG_REQ_O         = req;
  assign ENG_START_O       = start;
  assign ENG_ABORT_O       = abort;
  assign RESPONSE_AVAILABLE_FLAG_O = response_available_flag;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_wback_post;
    state == ST_WBACK ##1 state == ST_POST;
  endsequence

  sequence s_check_begin;
    state == ST_CHECK ##1 fw.inprog;
  endsequence

  a_inprog_set: assert property (
    state == ST_CHECK |-> s_check_begin)
    else $error("in-progress bit not set after check");

  a_eol_flag: assert property (
    state == ST_WBACK |=> fw.eol == $past(eol_req))
    else $error("end-of-list bit does not follow request");

  a_no_reserved: assert property (
    state == ST_POST |-> fw.status != `SCCE_CC_RSVD)
    else $error("reserved completion code posted");

  a_post_order: assert property (
    $rose(response_available_flag)
    |-> $past(state, 2) == ST_WBACK && fw.status == $past(code, 2))
    else $error("block posted before write-back");

  a_devpar_word: assert property (
    state == ST_POST && fw.code == `SCCE_FN_DEVPAR && fw.status == `SCCE_CC_OK
    |-> word[`SCCE_IDX_PARAM1][23:16] == `SCCE_LINE_COUNT
        && word[`SCCE_IDX_PARAM1][15:8] != 8'h00)
    else $error("device parameters not returned");

  a_len_used: assert property (
    state == ST_ENGINE && ENG_DONE_I
    |-> ##2 word[`SCCE_IDX_LEN][15:0] == $past(ENG_RSP_I.count, 2))
    else $error("length used not written back");

  a_addr_abs: assert property (
    ENG_START_O |-> ENG_REQ_O.addr == word[`SCCE_IDX_ADDR][21:0])
    else $error("engine address is not the absolute buffer address");

  a_bad_chan: assert property (
    state == ST_CHECK && val_code == `SCCE_CC_CHAN |-> ##1 s_wback_post
    ##0 fw.status == `SCCE_CC_CHAN)
    else $error("illegal channel not reported");

  a_wait_one: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest not released after one cycle");
endmodule // scce_top
